// [src/hsw_pkg.sv]
// Shared constants, register map and types of the hot swap sequencer
package hsw_pkg;
  // Time base
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * TICK_US;

  // Documented times, in microseconds
  localparam int STARTUP_TIMER_US = 200_000;
  localparam int PG_DELAY_US = 20_000;
  localparam int OC_REG_US = 3_000;
  localparam int OC_FILTER_US = 100;
  localparam int VOLT_FILTER_US = 1_000;
  localparam int DIS_FILTER_US = 1_000;
  localparam int THERM_FILTER_US = 12;
  localparam int CHG_RISE_US = 1_000;

  // Same times as counts of ticks
  localparam int STARTUP_TIMER_TICKS = STARTUP_TIMER_US / TICK_US;
  localparam int PG_DELAY_TICKS = PG_DELAY_US / TICK_US;
  localparam int OC_REG_TICKS = OC_REG_US / TICK_US;
  localparam int OC_FILTER_TICKS = OC_FILTER_US / TICK_US;
  localparam int VOLT_FILTER_TICKS = VOLT_FILTER_US / TICK_US;
  localparam int DIS_FILTER_TICKS = DIS_FILTER_US / TICK_US;
  localparam int THERM_FILTER_TICKS = THERM_FILTER_US / TICK_US;
  localparam int CHG_RISE_TICKS = CHG_RISE_US / TICK_US;

  // Widths and limits
  localparam int LIM_W = 8;
  localparam int RETRY_W = 4;
  localparam int TMR_W = 18;
  localparam logic [RETRY_W-1:0] RETRY_MAX = 4'ha;

  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_LIMITS = 4'h8;
  localparam logic CTRL_RESET = 1'b0;
  localparam int CTRL_SOFT_DIS_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RETRY_LSB = 4;
  localparam int STAT_FLAG_LSB = 8;
  localparam int LIMIT_CHG_LSB = 8;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_TIMING,
    ST_CHARGE,
    ST_ENHANCED,
    ST_NORMAL,
    ST_OVERCURRENT,
    ST_LATCHED
  } hsw_state_t;

  // Filtered supervision conditions
  typedef struct packed {
    logic uv;
    logic ov;
    logic ot;
    logic dis;
    logic oc;
  } hsw_cond_t;

  // Pass switch drive
  typedef struct packed {
    logic switch_on;
    logic fast_discharge;
    logic full_enhance;
    logic oc_flag;
  } hsw_drive_t;
endpackage

// [src/hsw_tick_div.sv]
// Divider that makes the one-cycle time base tick
`timescale 1ns/10ps
module hsw_tick_div
  import hsw_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  output logic tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

// [src/hsw_persist_filter.sv]
// Persistence filter: output follows the input only after LEN ticks of disagreement
`timescale 1ns/10ps
module hsw_persist_filter #(
  parameter int LEN = 1
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic tick_i,
  input wire logic level_i,
  output logic state_o
);
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);

  logic [CW-1:0] cnt_q;

  // Symmetric: a fault and its recovery both need the full time
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= '0;
      state_o <= 1'b0;
    end
    else if (level_i == state_o)
      cnt_q <= '0;
    else if (tick_i)
    begin
      if (cnt_q == LAST)
      begin
        state_o <= level_i;
        cnt_q <= '0;
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// [src/hsw_sequencer.sv]
// Hot swap start-up, charging and fault supervision sequencer
//
// Contract
// - Power-up: switch off, good low, retries cleared
// - Disabled at power-up: no sequencing starts
// - After lockout clears: sample limits, start timer
// - Voltage faults in start-up retry forever
// - Heat or disable restarts timer, counts retry
// - Stop after ten retries; disable clears
// - Start-up needs voltages, temperature and enable good
// - Charge after full timer and retries at most ten
// - Ramp charging limit from zero, not stepped
// - Near rail: full enhance, overcurrent limit
// - Good after delay, normal mode, clear retries
// - Any violation after enhancement restarts sequence
// - Filtered overcurrent flags and regulates at limit
// - Overcurrent held full time: off, restart
// - Overcurrent cleared early: normal, good kept
// - Short circuit: fast discharge, overcurrent mode
// - Filtered disable turns switch off, good low
// - Filtered enable starts new start-up sequence
// - Board removal undervoltage turns switch off
// - Start-up timer lasts two hundred milliseconds
// - Voltage fault and recovery filtered one millisecond
// - Over-temperature filtered twelve microseconds
`timescale 1ns/10ps
module hsw_sequencer
  import hsw_pkg::*;
#(
  parameter int TIMER_TICKS = STARTUP_TIMER_TICKS,
  parameter int PGOOD_TICKS = PG_DELAY_TICKS,
  parameter int OCREG_TICKS = OC_REG_TICKS,
  parameter int OCFILT_TICKS = OC_FILTER_TICKS,
  parameter int VFILT_TICKS = VOLT_FILTER_TICKS,
  parameter int DFILT_TICKS = DIS_FILTER_TICKS,
  parameter int TFILT_TICKS = THERM_FILTER_TICKS,
  parameter int RISE_TICKS = CHG_RISE_TICKS,
  parameter int TICK_DIV = TICK_CYCLES
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic supply_lockout_i,
  input wire logic under_volt_i,
  input wire logic over_volt_i,
  input wire logic over_temp_i,
  input wire logic disable_i,
  input wire logic over_current_i,
  input wire logic short_circuit_i,
  input wire logic output_near_rail_i,
  input wire logic [LIM_W-1:0] overcurrent_limit_set_i,
  input wire logic [LIM_W-1:0] charging_current_set_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output hsw_drive_t gate_o,
  output logic [LIM_W-1:0] current_limit_o,
  output logic power_good_high_o,
  output logic power_good_low_n_o
);
  localparam int NPIN = 8 + 2 * LIM_W;
  localparam logic [NPIN-1:0] PIN_RST = NPIN'(1); // Lockout reads asserted until the real pin level is through
  localparam logic [TMR_W-1:0] TIMER_LAST = TMR_W'(TIMER_TICKS - 1);
  localparam logic [TMR_W-1:0] PGOOD_LAST = TMR_W'(PGOOD_TICKS - 1);
  localparam logic [TMR_W-1:0] OCREG_LAST = TMR_W'(OCREG_TICKS - 1);
  localparam int STEP_RAW = RISE_TICKS / (2 ** LIM_W);
  localparam int STEP_TICKS = (STEP_RAW > 0) ? STEP_RAW : 1;
  localparam logic [TMR_W-1:0] STEP_LAST = TMR_W'(STEP_TICKS - 1);

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_sync_q;
  logic tick;
  logic lockout_s;
  logic uv_s;
  logic ov_s;
  logic ot_s;
  logic dis_s;
  logic oc_s;
  logic sc_s;
  logic near_s;
  logic soft_dis_q;
  hsw_cond_t cond;
  hsw_state_t state_q;
  hsw_state_t state_d;
  logic [TMR_W-1:0] timer_q;
  logic [TMR_W-1:0] step_q;
  logic timer_clr;
  logic [RETRY_W-1:0] retry_q;
  logic retry_inc;
  logic retry_clr;
  logic heat_dis_q;
  logic heat_dis_evt;
  logic cap_lim;
  logic [LIM_W-1:0] oc_lim_q;
  logic [LIM_W-1:0] chg_lim_q;
  logic [LIM_W-1:0] ramp_q;
  logic viol;
  logic pg_d;
  logic [31:0] rdata_d;

  function automatic logic switch_state(input hsw_state_t s);
    switch_state = (s == ST_CHARGE) || (s == ST_ENHANCED) ||
                   (s == ST_NORMAL) || (s == ST_OVERCURRENT);
  endfunction

  // Every pin, straps included, is double-registered before use
  assign pin_raw = {charging_current_set_i, overcurrent_limit_set_i,
                    output_near_rail_i, short_circuit_i, over_current_i, disable_i,
                    over_temp_i, over_volt_i, under_volt_i, supply_lockout_i};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          pin_meta_q[gi] <= PIN_RST[gi];
          pin_sync_q[gi] <= PIN_RST[gi];
        end
        else
        begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  assign lockout_s = pin_sync_q[0];
  assign uv_s = pin_sync_q[1];
  assign ov_s = pin_sync_q[2];
  assign ot_s = pin_sync_q[3];
  assign dis_s = pin_sync_q[4] | soft_dis_q;
  assign oc_s = pin_sync_q[5];
  assign sc_s = pin_sync_q[6];
  assign near_s = pin_sync_q[7];

  hsw_tick_div #(.DIV(TICK_DIV)) u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );

  hsw_persist_filter #(.LEN(VFILT_TICKS)) u_uv_filt (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tick_i(tick),
    .level_i(uv_s), .state_o(cond.uv)
  );
  hsw_persist_filter #(.LEN(VFILT_TICKS)) u_ov_filt (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tick_i(tick),
    .level_i(ov_s), .state_o(cond.ov)
  );
  hsw_persist_filter #(.LEN(TFILT_TICKS)) u_ot_filt (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tick_i(tick),
    .level_i(ot_s), .state_o(cond.ot)
  );
  hsw_persist_filter #(.LEN(DFILT_TICKS)) u_dis_filt (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tick_i(tick),
    .level_i(dis_s), .state_o(cond.dis)
  );
  hsw_persist_filter #(.LEN(OCFILT_TICKS)) u_oc_filt (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tick_i(tick),
    .level_i(oc_s), .state_o(cond.oc)
  );

  // Board removal shows up as the undervoltage term
  assign viol = cond.uv | cond.ov | cond.ot | cond.dis;
  assign heat_dis_evt = (cond.ot | cond.dis) & ~heat_dis_q;

  always_comb
  begin
    state_d = state_q;
    timer_clr = 1'b0;
    retry_inc = 1'b0;
    retry_clr = 1'b0;
    cap_lim = 1'b0;
    case (state_q)
      ST_OFF:
      begin
        if (tick && !lockout_s && !dis_s && !cond.dis)
        begin
          cap_lim = 1'b1;
          state_d = ST_TIMING;
        end
      end
      ST_TIMING:
      begin
        if (tick)
        begin
          if (cond.uv || cond.ov)
            timer_clr = 1'b1;
          else if (heat_dis_evt)
          begin
            timer_clr = 1'b1;
            if (retry_q >= RETRY_MAX)
              state_d = ST_LATCHED;
            else
              retry_inc = 1'b1;
          end
          else if (cond.ot || cond.dis)
            timer_clr = 1'b1;
          else if (timer_q == TIMER_LAST && retry_q <= RETRY_MAX)
            state_d = ST_CHARGE;
        end
      end
      ST_CHARGE:
      begin
        if (tick && viol)
          state_d = ST_TIMING;
        else if (tick && near_s)
          state_d = ST_ENHANCED;
      end
      ST_ENHANCED:
      begin
        if (tick && viol)
          state_d = ST_TIMING;
        else if (tick && timer_q == PGOOD_LAST)
        begin
          state_d = ST_NORMAL;
          retry_clr = 1'b1;
        end
      end
      ST_NORMAL:
      begin
        if (tick && viol)
          state_d = ST_TIMING;
        else if (sc_s)
          state_d = ST_OVERCURRENT;
        else if (tick && cond.oc && oc_s)
          state_d = ST_OVERCURRENT;
      end
      ST_OVERCURRENT:
      begin
        if (tick && viol)
          state_d = ST_TIMING;
        else if (tick && !oc_s && !sc_s)
          state_d = ST_NORMAL;
        else if (tick && timer_q == OCREG_LAST)
          state_d = ST_TIMING;
      end
      ST_LATCHED:
      begin
        // Heat clearing alone is not enough; only a disable frees the block
        if (tick && cond.dis)
          retry_clr = 1'b1;
        else if (tick && retry_q == '0)
          state_d = ST_TIMING;
      end
      default:
        state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  // One timer serves start-up, good delay and regulation; restarts on entry
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      timer_q <= '0;
    else if (timer_clr || state_d != state_q)
      timer_q <= '0;
    else if (tick && timer_q != '1)
      timer_q <= timer_q + 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      heat_dis_q <= 1'b0;
    else if (tick)
      heat_dis_q <= cond.ot | cond.dis;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      retry_q <= '0;
    else if (retry_clr)
      retry_q <= '0;
    else if (retry_inc && retry_q < RETRY_MAX)
      retry_q <= retry_q + 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      oc_lim_q <= '0;
      chg_lim_q <= '0;
    end
    else if (cap_lim)
    begin
      oc_lim_q <= pin_sync_q[8 +: LIM_W];
      chg_lim_q <= pin_sync_q[8 + LIM_W +: LIM_W];
    end
  end

  // Limit climbs one code per step so the input line sees no current step
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ramp_q <= '0;
      step_q <= '0;
    end
    else if (state_q != ST_CHARGE)
    begin
      ramp_q <= '0;
      step_q <= '0;
    end
    else if (tick && ramp_q != chg_lim_q)
    begin
      if (step_q == STEP_LAST)
      begin
        step_q <= '0;
        ramp_q <= ramp_q + 1'b1;
      end
      else
        step_q <= step_q + 1'b1;
    end
  end

  assign pg_d = (state_d == ST_NORMAL) || (state_d == ST_OVERCURRENT);

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      power_good_high_o <= 1'b0;
      power_good_low_n_o <= 1'b1;
    end
    else
    begin
      power_good_high_o <= pg_d;
      power_good_low_n_o <= ~pg_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gate_o <= '0;
      current_limit_o <= '0;
    end
    else
    begin
      gate_o.switch_on <= switch_state(state_d);
      gate_o.fast_discharge <= sc_s && switch_state(state_d);
      gate_o.full_enhance <= (state_d == ST_ENHANCED) || (state_d == ST_NORMAL);
      gate_o.oc_flag <= (state_d == ST_OVERCURRENT);
      case (state_d)
        ST_CHARGE:
          current_limit_o <= ramp_q;
        ST_ENHANCED, ST_NORMAL, ST_OVERCURRENT:
          current_limit_o <= oc_lim_q;
        default:
          current_limit_o <= '0;
      endcase
    end
  end

  // Avalon slave: waitrequest drops for one cycle, the cycle after a request
  always_comb
  begin
    rdata_d = '0;
    case (avs_address_i)
      REG_CTRL:
        rdata_d[CTRL_SOFT_DIS_BIT] = soft_dis_q;
      REG_STATUS:
      begin
        rdata_d[STAT_STATE_LSB +: 4] = {1'b0, state_q};
        rdata_d[STAT_RETRY_LSB +: RETRY_W] = retry_q;
        rdata_d[STAT_FLAG_LSB +: 8] = {1'b0, cond, gate_o.switch_on, power_good_high_o};
      end
      REG_LIMITS:
      begin
        rdata_d[0 +: LIM_W] = oc_lim_q;
        rdata_d[LIMIT_CHG_LSB +: LIM_W] = chg_lim_q;
      end
      default:
        rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end
    else
    begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o)
        avs_readdata_o <= rdata_d;
    end
  end

  // Software disable still passes the disable filter
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      soft_dis_q <= CTRL_RESET;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL && avs_byteenable_i[0])
      soft_dis_q <= avs_writedata_i[CTRL_SOFT_DIS_BIT];
  end
endmodule

// [tb/hsw_sequencer_asserts.sv]
// Port-level concurrent checks for the hot swap sequencer
`timescale 1ns/10ps
module hsw_sequencer_asserts
  import hsw_pkg::*;
#(
  parameter int TICK_DIV = 2,
  parameter int PGOOD_TICKS = 10,
  parameter int OCREG_TICKS = 8,
  parameter int DFILT_TICKS = 4
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic disable_i,
  input wire logic short_circuit_i,
  input wire logic [LIM_W-1:0] overcurrent_limit_set_i,
  input wire hsw_drive_t gate_o,
  input wire logic [LIM_W-1:0] current_limit_o,
  input wire logic power_good_high_o,
  input wire logic power_good_low_n_o
);
  // Bounds allow for pin sync and tick phase on top of the counted ticks
  localparam int PG_MAX = (PGOOD_TICKS + 3) * TICK_DIV + 4;
  localparam int OC_MAX = (OCREG_TICKS + 3) * TICK_DIV + 4;
  localparam int DIS_MAX = (DFILT_TICKS + 3) * TICK_DIV + 4;
  logic [15:0] oc_cnt_q;
  logic [15:0] dis_cnt_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      oc_cnt_q <= 16'h0000;
    else
      oc_cnt_q <= gate_o.oc_flag ? oc_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      dis_cnt_q <= 16'h0000;
    else
      dis_cnt_q <= disable_i ? dis_cnt_q + 16'h0001 : 16'h0000;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_enh;
    $rose(gate_o.full_enhance) && !power_good_high_o;
  endsequence
  sequence s_turn_on;
    $rose(gate_o.switch_on);
  endsequence
  property p_pg_pair;
    power_good_low_n_o == !power_good_high_o;
  endproperty
  a_pg_pair: assert property (p_pg_pair) else $error("power good outputs not complementary");
  property p_off_limit;
    !gate_o.switch_on |-> current_limit_o == 8'h00;
  endproperty
  a_off_limit: assert property (p_off_limit) else $error("limit nonzero with switch off");
  property p_ramp_zero;
    s_turn_on |-> current_limit_o == 8'h00 && !gate_o.full_enhance;
  endproperty
  a_ramp_zero: assert property (p_ramp_zero) else $error("charging limit not starting at zero");
  property p_ramp_step;
    gate_o.switch_on && !gate_o.full_enhance && $past(gate_o.switch_on) |->
      current_limit_o == $past(current_limit_o) || current_limit_o == $past(current_limit_o) + 8'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("charging limit stepped");
  property p_enh_limit;
    gate_o.full_enhance |-> current_limit_o == overcurrent_limit_set_i;
  endproperty
  a_enh_limit: assert property (p_enh_limit) else $error("enhanced without overcurrent limit");
  property p_pg_hold;
    s_enh |-> !power_good_high_o [*8];
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("power good too early");
  property p_pg_rise;
    s_enh |-> ##[1:PG_MAX] (power_good_high_o || !gate_o.full_enhance);
  endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("power good late");
  property p_pg_needs_on;
    power_good_high_o |-> gate_o.switch_on && (gate_o.full_enhance || gate_o.oc_flag);
  endproperty
  a_pg_needs_on: assert property (p_pg_needs_on) else $error("power good with switch not enhanced");
  property p_oc_keep_pg;
    gate_o.oc_flag |-> power_good_high_o;
  endproperty
  a_oc_keep_pg: assert property (p_oc_keep_pg) else $error("power good lost during regulation");
  property p_oc_timeout;
    oc_cnt_q <= 16'(OC_MAX);
  endproperty
  a_oc_timeout: assert property (p_oc_timeout) else $error("overcurrent regulation too long");
  property p_short;
    $rose(short_circuit_i) && gate_o.switch_on |-> ##[1:4] (gate_o.fast_discharge || !gate_o.switch_on);
  endproperty
  a_short: assert property (p_short) else $error("short not discharged fast");
  property p_dis_off;
    dis_cnt_q >= 16'(DIS_MAX) |-> !gate_o.switch_on && !power_good_high_o;
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("switch on while disabled");
endmodule

bind hsw_sequencer hsw_sequencer_asserts #(.TICK_DIV(TICK_DIV), .PGOOD_TICKS(PGOOD_TICKS),
  .OCREG_TICKS(OCREG_TICKS), .DFILT_TICKS(DFILT_TICKS)) u_chk (.ref_clk_i, .rst_b_i, .disable_i,
  .short_circuit_i, .overcurrent_limit_set_i, .gate_o, .current_limit_o, .power_good_high_o, .power_good_low_n_o);

// [tb/hsw_load_model.sv]
// Load capacitor and host disable control facing the sequencer
`timescale 1ns/10ps
module hsw_load_model
  import hsw_pkg::*;
#(
  parameter int CHARGE_CYCLES = 40
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire hsw_drive_t gate_i,
  input wire logic host_dis_i,
  output logic output_near_rail_o,
  output logic disable_o
);
  logic [15:0] chg_cnt_q;
  // Capacitor charges only while the switch conducts and empties at once when it opens
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      chg_cnt_q <= 16'h0000;
    else
      chg_cnt_q <= gate_i.switch_on ? chg_cnt_q + 16'(chg_cnt_q < 16'(CHARGE_CYCLES)) : 16'h0000;
  assign output_near_rail_o = chg_cnt_q >= 16'(CHARGE_CYCLES);
  // Host holds each disable level well past the filter time
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      disable_o <= 1'b1;
    else
      disable_o <= host_dis_i;
endmodule

// [tb/hsw_sequencer_tb.sv]
// Self-checking testbench for the hot swap sequencer
`timescale 1ns/10ps
module hsw_sequencer_tb;
  import hsw_pkg::*;
  localparam int TDIV = 2;
  localparam int TMR = 20;
  localparam int DFT = 4;
  localparam logic [LIM_W-1:0] OC_CODE = 8'h5a;
  localparam logic [LIM_W-1:0] CHG_CODE = 8'h03;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic lock = 1'b1, uv = 1'b0, oc = 1'b0, sc = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [2:0] flt = 3'b100;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [3:0] be = 4'hf;
  logic [LIM_W-1:0] oc_set = OC_CODE, chg_set = CHG_CODE;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic wreq, near, dis, pgh, pgl;
  logic [LIM_W-1:0] lim;
  hsw_drive_t gate;
  int err_total = 0, total_checks = 0, n;
  always #5 ref_clk_i = ~ref_clk_i;
  hsw_sequencer #(.TIMER_TICKS(TMR), .PGOOD_TICKS(10), .OCREG_TICKS(8), .OCFILT_TICKS(4), .VFILT_TICKS(4),
    .DFILT_TICKS(DFT), .TFILT_TICKS(2), .TICK_DIV(TDIV)) dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .supply_lockout_i(lock), .under_volt_i(uv), .over_volt_i(flt[0]), .over_temp_i(flt[1]), .disable_i(dis),
    .over_current_i(oc), .short_circuit_i(sc), .output_near_rail_i(near), .overcurrent_limit_set_i(oc_set),
    .charging_current_set_i(chg_set), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .gate_o(gate), .current_limit_o(lim), .power_good_high_o(pgh), .power_good_low_n_o(pgl));
  hsw_load_model #(.CHARGE_CYCLES(40)) u_load (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .gate_i(gate),
    .host_dis_i(flt[2]), .output_near_rail_o(near), .disable_o(dis));
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idx 4 is power good, 3..0 the gate drive bits
  task automatic wait_sig(input int idx, input logic exp, input int bound);
    n = 0;
    while (((({pgh, gate} >> idx) & 5'h01) !== 5'(exp)) && n < bound)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= bound)
    begin
      err_total++;
      $display("[ERR] t=%0t wait idx %0d got=%h exp=%h", $time, idx, {pgh, gate}, exp);
      print_verdict();
    end
  endtask
  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge ref_clk_i);
      k++;
    end
    while (wreq !== 1'b0 && k < 50);
    st = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 50)
    begin
      err_total++;
      $display("[ERR] t=%0t bus wait got=%h exp=%h", $time, wreq, 1'b0);
      print_verdict();
    end
  endtask
  task automatic t_power_up;
    lock <= 1'b0;
    repeat (200) @(posedge ref_clk_i);
    check({pgh, pgl, gate, lim}, 14'h1000);
    bus(1'b0, REG_STATUS, 32'h0);
    check(st, 32'h0000_0800);
    bus(1'b0, 4'hc, 32'h0);
    check(st, 32'h0);
    be <= 4'he;
    bus(1'b1, REG_CTRL, 32'h1);
    be <= 4'hf;
    bus(1'b0, REG_CTRL, 32'h0);
    check(st, 32'h0);
    $display("test power_up done");
  endtask
  task automatic t_start;
    flt <= 3'b000;
    wait_sig(3, 1'b1, 400);
    check(n >= (TMR + DFT) * TDIV, 1'b1);
    repeat (30) @(posedge ref_clk_i);
    check(lim, CHG_CODE);
    wait_sig(4, 1'b1, 400);
    check(lim, OC_CODE);
    bus(1'b0, REG_LIMITS, 32'h0);
    check(st, {16'h0, CHG_CODE, OC_CODE});
    bus(1'b0, REG_STATUS, 32'h0);
    check(st, 32'h0000_0304);
    $display("test start done");
  endtask
  task automatic t_overcurrent;
    oc <= 1'b1;
    wait_sig(0, 1'b1, 40);
    repeat (4) @(posedge ref_clk_i);
    oc <= 1'b0;
    wait_sig(0, 1'b0, 40);
    check({pgh, gate.switch_on}, 2'b11);
    oc <= 1'b1;
    wait_sig(4, 1'b0, 80);
    check(gate.switch_on, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    check(st[3:0], 4'h1);
    oc <= 1'b0;
    wait_sig(4, 1'b1, 400);
    sc <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    check(gate.fast_discharge, 1'b1);
    wait_sig(0, 1'b1, 10);
    sc <= 1'b0;
    wait_sig(0, 1'b0, 40);
    check(pgh, 1'b1);
    $display("test overcurrent done");
  endtask
  task automatic t_faults;
    for (int i = 0; i < 3; i++)
    begin
      flt <= 3'(1 << i);
      wait_sig(4, 1'b0, 60);
      repeat (20) @(posedge ref_clk_i);
      check(gate.switch_on, 1'b0);
      flt <= 3'b000;
      wait_sig(4, 1'b1, 400);
    end
    $display("test faults done");
  endtask
  task automatic t_retry;
    uv <= 1'b1;
    wait_sig(4, 1'b0, 60);
    repeat (40) @(posedge ref_clk_i);
    bus(1'b0, REG_STATUS, 32'h0);
    check(st[9:0], 10'h001);
    uv <= 1'b0;
    repeat (14) @(posedge ref_clk_i);
    for (int i = 0; i < 11; i++)
    begin
      flt <= 3'b010;
      repeat (10) @(posedge ref_clk_i);
      flt <= 3'b000;
      repeat (10) @(posedge ref_clk_i);
    end
    bus(1'b0, REG_STATUS, 32'h0);
    check(st[9:0], 10'h0a6);
    repeat (100) @(posedge ref_clk_i);
    check(gate.switch_on, 1'b0);
    bus(1'b1, REG_CTRL, 32'h1);
    repeat (30) @(posedge ref_clk_i);
    bus(1'b0, REG_STATUS, 32'h0);
    check(st[7:4], 4'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    wait_sig(4, 1'b1, 400);
    $display("test retry done");
  endtask
  // Mid-run reset with new strap codes: limits are sampled again on the way out of OFF
  task automatic t_reset;
    oc_set <= 8'h21;
    chg_set <= 8'h07;
    rst_b_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    check({pgh, pgl, gate, lim}, 14'h1000);
    rst_b_i <= 1'b1;
    wait_sig(4, 1'b1, 400);
    bus(1'b0, REG_LIMITS, 32'h0);
    check(st, 32'h0000_0721);
    $display("test reset done");
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_power_up();
    t_start();
    t_overcurrent();
    t_faults();
    t_retry();
    t_reset();
    print_verdict();
  end
endmodule
